// >>> rtl/dio_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the digital input/output conditioning block.
// Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef DIO_REGS_SVH
`define DIO_REGS_SVH

`define DIO_ADDR_W 12
`define DIO_NUM_IN 16
`define DIO_NUM_OUT 16
`define DIO_NUM_AUX 7
`define DIO_ROUTE_ENTRIES 32
`define DIO_LEVEL_LSB 16

`define DIO_OFS_IN_GATE 12'h000
`define DIO_OFS_IN_POL 12'h004
`define DIO_OFS_IN_FORCE_EN 12'h008
`define DIO_OFS_IN_FORCE_VAL 12'h00c
`define DIO_OFS_IN_RAW 12'h010
`define DIO_OFS_IN_ROUTE_EN 12'h014
`define DIO_OFS_IN_SUMMARY 12'h018
`define DIO_OFS_OUT_CMD 12'h01c
`define DIO_OFS_OUT_UNUSED_FIRST 12'h020
`define DIO_OFS_OUT_POL 12'h024
`define DIO_OFS_OUT_MAN_EN 12'h028
`define DIO_OFS_OUT_MAN_VAL 12'h02c
`define DIO_OFS_OUT_UNUSED_COMPAT 12'h030
`define DIO_OFS_ROUTE_TAB 12'h100
`define DIO_ROUTE_TAB_SEL 5'h02

`define DIO_RST_WORD 32'h0000_0000
`define DIO_RST_SRC 8'h00

`define DIO_BIT_NEG_LIMIT 0
`define DIO_BIT_POS_LIMIT 1
`define DIO_BIT_HOME 2
`define DIO_BIT_BRAKE 0
`define DIO_BIT_ROUTE_EN 0

`define DIO_SRC_INV_BIT 7
`define DIO_SRC_CONST 7'h00
`define DIO_SRC_PHYS_FIRST 7'h01
`define DIO_SRC_PHYS_LAST 7'h10
`define DIO_SRC_AUX_FIRST 7'h41
`define DIO_SRC_AUX_LAST 7'h47

`define DIO_RESP_OKAY 2'b00
`define DIO_RESP_SLVERR 2'b10

`define DIO_SAMPLE_PERIOD_NS 1000000
`define DIO_CLK_FREQ_MHZ 200
`define DIO_SAMPLE_CYCLES (`DIO_SAMPLE_PERIOD_NS * `DIO_CLK_FREQ_MHZ / 1000)

`endif

// >>> rtl/dio_pkg.sv
// Types shared by the digital input/output conditioning block.
// Assumes dio_regs.svh is on the include path.
`include "dio_regs.svh"

package dio_pkg;

   typedef struct packed {
      logic awvalid;
      logic [`DIO_ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [`DIO_ADDR_W-1:0] araddr;
      logic rready;
   } axil_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_s;

   // Hall, encoder and USB power senses in routing-source order
   typedef struct packed {
      logic usb_power;
      logic enc_index;
      logic enc_b;
      logic enc_a;
      logic hall_w;
      logic hall_v;
      logic hall_u;
   } aux_src_s;

   typedef logic [`DIO_ROUTE_ENTRIES-1:0][7:0] route_tab_t;

   typedef struct packed {
      logic aw_have;
      logic [`DIO_ADDR_W-1:0] awaddr;
      logic w_have;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      axil_rsp_s rsp;
      logic [31:0] in_gate;
      logic [31:0] in_pol;
      logic [31:0] force_en;
      logic [31:0] force_val;
      logic route_en;
      route_tab_t route_tab;
      logic [`DIO_NUM_IN-1:0] phys_smp;
      logic [`DIO_NUM_AUX-1:0] aux_smp;
      logic [31:0] summary;
      logic [31:0] out_cmd;
      logic [31:0] out_pol;
      logic [31:0] man_en;
      logic [31:0] man_val;
      logic [`DIO_NUM_OUT-1:0] dout;
      logic brake;
   } dio_state_s;

   typedef struct packed {
      logic [31:0] count;
      logic tick;
   } tick_state_s;

endpackage

// >>> rtl/dio_sample_tick.sv
// Sampling-rate divider: one-cycle enable pulse every PERIOD clocks.
// Assumes one free-running system clock.
`timescale 1ns/1ps
`include "dio_regs.svh"

module dio_sample_tick #(
   parameter int unsigned PERIOD = `DIO_SAMPLE_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   output logic tick_o
);
   import dio_pkg::*;

   tick_state_s st_q;
   tick_state_s st_d;

   always_comb begin
      st_d = st_q;
      st_d.tick = 1'b0;
      if (st_q.count >= 32'(PERIOD - 1)) begin
         st_d.count = 32'h0000_0000;
         st_d.tick = 1'b1;
      end else begin
         st_d.count = st_q.count + 32'h0000_0001;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign tick_o = st_q.tick;
endmodule

// >>> rtl/dio_route_mux.sv
// One routing selector: picks a source bit by its 8-bit source code.
// Assumes the source vectors are already sampled.
`timescale 1ns/1ps
`include "dio_regs.svh"

module dio_route_mux (
   input wire logic [7:0] code_i,
   input wire logic [`DIO_NUM_IN-1:0] phys_i,
   input wire logic [`DIO_NUM_AUX-1:0] aux_i,
   output logic bit_o
);
   import dio_pkg::*;

   logic [6:0] sel;
   logic plain;

   always_comb begin
      sel = code_i[6:0];
      plain = 1'b0;
      if (sel >= `DIO_SRC_PHYS_FIRST && sel <= `DIO_SRC_PHYS_LAST) begin
         plain = phys_i[4'(sel - `DIO_SRC_PHYS_FIRST)];
      end else if (sel >= `DIO_SRC_AUX_FIRST && sel <= `DIO_SRC_AUX_LAST) begin
         plain = aux_i[3'(sel - `DIO_SRC_AUX_FIRST)];
      end
   end

   assign bit_o = plain ^ code_i[`DIO_SRC_INV_BIT];
endmodule

// >>> rtl/dio_conditioning.sv
// Digital input/output conditioning with an AXI4-Lite register slave.
// Assumes inputs synchronous to sys_clk_i and a single-master register bus.
//
// What this block does
// - Every input configuration bit acts only on the input at its position.
// - Gate bit 0 disables, 1 enables a special function; never touches level bits.
// - Gate bit 0 negative limit, bit 1 positive limit, bit 2 home.
// - Polarity bit n set makes a high input n+1 read as 0.
// - Force-enable bit set substitutes a software value for the sampled input.
// - Force-value bit gives the reading used when its force-enable is set.
// - Raw-level word shows sampled inputs untouched by invert, force or gate.
// - Input 1: negative-limit result in bit 0, processed level in bit 16.
// - Routing enable set makes gate, polarity and force entries inert.
// - Enabling routing loads a table reproducing prior input behaviour.
// - Routing entry k drives bit k of the input summary word.
// - Codes 00 zero, 01-10 inputs, 41-43 Hall, 44-46 encoder, 47 USB.
// - Codes with top bit set give the inverse: 80 one, 81-90, C1-C7.
// - Output n driven from command bit 15+n; low bits are special outputs.
// - Command bit 0 drives the brake output.
// - Output polarity bit set turns a command 1 into a low pin.
// - Manual-enable bit set takes the pin value from the manual-value word.
// - First and fifth output configuration words accepted but without effect.
// - Inputs sampled once per millisecond; shorter pulses may be missed.
// - Level bit reflects the input whether or not its special function is on.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "dio_regs.svh"

module dio_conditioning #(
   parameter int unsigned SAMPLE_CYCLES = `DIO_SAMPLE_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire dio_pkg::axil_req_s axil_req_i,
   output dio_pkg::axil_rsp_s axil_rsp_o,
   input wire logic [`DIO_NUM_IN-1:0] phys_in_i,
   input wire dio_pkg::aux_src_s aux_in_i,
   output logic [`DIO_NUM_OUT-1:0] dout_o,
   output logic brake_o
);
   import dio_pkg::*;

   dio_state_s st_q;
   dio_state_s st_d;
   logic sample_tick;
   logic [`DIO_ROUTE_ENTRIES-1:0] route_bits;
   logic [`DIO_NUM_IN-1:0] forced;
   logic [`DIO_NUM_IN-1:0] processed;
   logic [31:0] normal_word;
   logic [31:0] out_sel;
   logic [31:0] out_pin;

   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic route_tab_t seed_table(input logic [31:0] gate,
                                             input logic [31:0] pol,
                                             input logic [31:0] fen,
                                             input logic [31:0] fval);
      route_tab_t tab;
      logic [3:0] n;
      tab = '0;
      for (int k = 0; k < `DIO_ROUTE_ENTRIES; k++) begin
         n = k[3:0];
         if (fen[n]) begin
            tab[k] = {fval[n] ^ pol[n], `DIO_SRC_CONST};
         end else begin
            tab[k] = {pol[n], 7'({3'h0, n} + `DIO_SRC_PHYS_FIRST)};
         end
         if (k < `DIO_LEVEL_LSB && !gate[k]) begin
            tab[k] = `DIO_RST_SRC;
         end
      end
      return tab;
   endfunction

   dio_sample_tick #(
      .PERIOD(SAMPLE_CYCLES)
   ) u_tick (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .tick_o(sample_tick)
   );

   genvar gi;
   generate
      for (gi = 0; gi < `DIO_ROUTE_ENTRIES; gi++) begin : g_route
         dio_route_mux u_mux (
            .code_i(st_q.route_tab[gi]),
            .phys_i(st_q.phys_smp),
            .aux_i(st_q.aux_smp),
            .bit_o(route_bits[gi])
         );
      end
   endgenerate

   always_comb begin
      forced = (st_q.phys_smp & ~st_q.force_en[`DIO_NUM_IN-1:0])
             | (st_q.force_val[`DIO_NUM_IN-1:0] & st_q.force_en[`DIO_NUM_IN-1:0]);
      processed = forced ^ st_q.in_pol[`DIO_NUM_IN-1:0];
      normal_word = {processed, processed & st_q.in_gate[`DIO_NUM_IN-1:0]};
   end

   always_comb begin
      out_sel = (st_q.out_cmd & ~st_q.man_en) | (st_q.man_val & st_q.man_en);
      out_pin = out_sel ^ st_q.out_pol;
   end

   always_comb begin
      logic [`DIO_ADDR_W-1:0] addr;
      logic [31:0] rd;
      logic hit;
      addr = '0;
      rd = `DIO_RST_WORD;
      hit = 1'b1;
      st_d = st_q;

      if (sample_tick) begin
         st_d.phys_smp = phys_in_i;
         st_d.aux_smp = aux_in_i;
      end

      st_d.summary = st_q.route_en ? route_bits : normal_word;

      // Output pins from bits 16 up
      st_d.dout = out_pin[`DIO_LEVEL_LSB +: `DIO_NUM_OUT];
      st_d.brake = out_pin[`DIO_BIT_BRAKE];

      if (axil_req_i.awvalid && st_q.rsp.awready) begin
         st_d.aw_have = 1'b1;
         st_d.awaddr = axil_req_i.awaddr;
      end
      if (axil_req_i.wvalid && st_q.rsp.wready) begin
         st_d.w_have = 1'b1;
         st_d.wdata = axil_req_i.wdata;
         st_d.wstrb = axil_req_i.wstrb;
      end
      if (st_q.rsp.bvalid && axil_req_i.bready) begin
         st_d.rsp.bvalid = 1'b0;
      end

      if (st_d.aw_have && st_d.w_have && !st_d.rsp.bvalid) begin
         addr = {st_d.awaddr[`DIO_ADDR_W-1:2], 2'b00};
         st_d.aw_have = 1'b0;
         st_d.w_have = 1'b0;
         st_d.rsp.bvalid = 1'b1;
         if (addr == `DIO_OFS_IN_GATE) begin
            st_d.in_gate = merge_strb(st_q.in_gate, st_d.wdata, st_d.wstrb);
         end else if (addr == `DIO_OFS_IN_POL) begin
            st_d.in_pol = merge_strb(st_q.in_pol, st_d.wdata, st_d.wstrb);
         end else if (addr == `DIO_OFS_IN_FORCE_EN) begin
            st_d.force_en = merge_strb(st_q.force_en, st_d.wdata, st_d.wstrb);
         end else if (addr == `DIO_OFS_IN_FORCE_VAL) begin
            st_d.force_val = merge_strb(st_q.force_val, st_d.wdata, st_d.wstrb);
         end else if (addr == `DIO_OFS_IN_ROUTE_EN) begin
            if (st_d.wstrb[0]) begin
               st_d.route_en = st_d.wdata[`DIO_BIT_ROUTE_EN];
               if (st_d.wdata[`DIO_BIT_ROUTE_EN] && !st_q.route_en) begin
                  st_d.route_tab = seed_table(st_q.in_gate, st_q.in_pol,
                                              st_q.force_en, st_q.force_val);
               end
            end
         end else if (addr == `DIO_OFS_OUT_CMD) begin
            st_d.out_cmd = merge_strb(st_q.out_cmd, st_d.wdata, st_d.wstrb);
         end else if (addr == `DIO_OFS_OUT_POL) begin
            st_d.out_pol = merge_strb(st_q.out_pol, st_d.wdata, st_d.wstrb);
         end else if (addr == `DIO_OFS_OUT_MAN_EN) begin
            st_d.man_en = merge_strb(st_q.man_en, st_d.wdata, st_d.wstrb);
         end else if (addr == `DIO_OFS_OUT_MAN_VAL) begin
            st_d.man_val = merge_strb(st_q.man_val, st_d.wdata, st_d.wstrb);
         end else if (addr == `DIO_OFS_OUT_UNUSED_FIRST ||
                      addr == `DIO_OFS_OUT_UNUSED_COMPAT) begin
            hit = 1'b1;
         end else if (addr == `DIO_OFS_IN_RAW || addr == `DIO_OFS_IN_SUMMARY) begin
            // Read-only words ignore writes but answer OKAY
            hit = 1'b1;
         end else if (addr[`DIO_ADDR_W-1:7] == `DIO_ROUTE_TAB_SEL) begin
            if (st_d.wstrb[0]) begin
               st_d.route_tab[addr[6:2]] = st_d.wdata[7:0];
            end
         end else begin
            hit = 1'b0;
         end
         st_d.rsp.bresp = hit ? `DIO_RESP_OKAY : `DIO_RESP_SLVERR;
      end

      if (st_q.rsp.rvalid && axil_req_i.rready) begin
         st_d.rsp.rvalid = 1'b0;
      end
      if (axil_req_i.arvalid && st_q.rsp.arready) begin
         addr = {axil_req_i.araddr[`DIO_ADDR_W-1:2], 2'b00};
         hit = 1'b1;
         if (addr == `DIO_OFS_IN_GATE) begin
            rd = st_q.in_gate;
         end else if (addr == `DIO_OFS_IN_POL) begin
            rd = st_q.in_pol;
         end else if (addr == `DIO_OFS_IN_FORCE_EN) begin
            rd = st_q.force_en;
         end else if (addr == `DIO_OFS_IN_FORCE_VAL) begin
            rd = st_q.force_val;
         end else if (addr == `DIO_OFS_IN_RAW) begin
            rd = {16'h0000, st_q.phys_smp};
         end else if (addr == `DIO_OFS_IN_ROUTE_EN) begin
            rd = {31'h0000_0000, st_q.route_en};
         end else if (addr == `DIO_OFS_IN_SUMMARY) begin
            rd = st_q.summary;
         end else if (addr == `DIO_OFS_OUT_CMD) begin
            rd = st_q.out_cmd;
         end else if (addr == `DIO_OFS_OUT_POL) begin
            rd = st_q.out_pol;
         end else if (addr == `DIO_OFS_OUT_MAN_EN) begin
            rd = st_q.man_en;
         end else if (addr == `DIO_OFS_OUT_MAN_VAL) begin
            rd = st_q.man_val;
         end else if (addr == `DIO_OFS_OUT_UNUSED_FIRST ||
                      addr == `DIO_OFS_OUT_UNUSED_COMPAT) begin
            rd = `DIO_RST_WORD;
         end else if (addr[`DIO_ADDR_W-1:7] == `DIO_ROUTE_TAB_SEL) begin
            rd = {24'h00_0000, st_q.route_tab[addr[6:2]]};
         end else begin
            hit = 1'b0;
         end
         st_d.rsp.rvalid = 1'b1;
         st_d.rsp.rdata = rd;
         st_d.rsp.rresp = hit ? `DIO_RESP_OKAY : `DIO_RESP_SLVERR;
      end

      // One outstanding write and one read; ready drops while busy
      st_d.rsp.awready = !st_d.aw_have && !st_d.rsp.bvalid;
      st_d.rsp.wready = !st_d.w_have && !st_d.rsp.bvalid;
      st_d.rsp.arready = !st_d.rsp.rvalid;
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign axil_rsp_o = st_q.rsp;
   assign dout_o = st_q.dout;
   assign brake_o = st_q.brake;
endmodule

// >>> sim/dio_field_model.sv
// Field side: switches and sensors around the block.
// Assumes the bench moves the levels just after a clock edge.
`timescale 1ns/1ps
module dio_field_model (
   input wire logic sys_clk_i,
   input wire logic [15:0] lvl_i,
   input wire dio_pkg::aux_src_s aux_lvl_i,
   output logic [15:0] phys_o,
   output dio_pkg::aux_src_s aux_o
);
   import dio_pkg::*;
   initial begin
      phys_o = 16'h0;
      aux_o = '0;
   end
   // Contacts settle one edge late, as a real switch would
   always @(posedge sys_clk_i) begin
      phys_o <= lvl_i;
      aux_o <= aux_lvl_i;
   end
endmodule

// >>> sim/dio_conditioning_chk.sv
// Assertions on the register bus handshake and output timing.
// Assumes it is bound to dio_conditioning and sees its ports only.
`timescale 1ns/1ps
`include "dio_regs.svh"
module dio_conditioning_chk #(
   parameter int unsigned SAMPLE_CYCLES = 8
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire dio_pkg::axil_req_s axil_req_i,
   input wire dio_pkg::axil_rsp_s axil_rsp_o,
   input wire logic [`DIO_NUM_IN-1:0] phys_in_i,
   input wire dio_pkg::aux_src_s aux_in_i,
   input wire logic [`DIO_NUM_OUT-1:0] dout_o,
   input wire logic brake_o
);
   import dio_pkg::*;
   logic aw_t;
   logic w_t;
   assign aw_t = axil_req_i.awvalid && axil_rsp_o.awready;
   assign w_t = axil_req_i.wvalid && axil_rsp_o.wready;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_wr_taken;
      aw_t && w_t;
   endsequence
   sequence s_b_done;
      axil_rsp_o.bvalid && axil_req_i.bready;
   endsequence
   sequence s_wr_free;
      !axil_rsp_o.bvalid && axil_rsp_o.awready && axil_rsp_o.wready;
   endsequence
   a_b_prompt: assert property (s_wr_taken |=> axil_rsp_o.bvalid)
      else $error("Write answer late");
   a_b_release: assert property (s_b_done |=> s_wr_free)
      else $error("Write side not freed");
   a_b_hold: assert property (axil_rsp_o.bvalid && !axil_req_i.bready |=>
      axil_rsp_o.bvalid && $stable(axil_rsp_o.bresp))
      else $error("Write answer dropped");
   a_aw_refused: assert property (axil_rsp_o.bvalid |->
      !axil_rsp_o.awready && !axil_rsp_o.wready)
      else $error("Write taken while answer pending");
   a_r_prompt: assert property (axil_req_i.arvalid && axil_rsp_o.arready |=> axil_rsp_o.rvalid)
      else $error("Read answer late");
   a_r_hold: assert property (axil_rsp_o.rvalid && !axil_req_i.rready |=>
      axil_rsp_o.rvalid && $stable(axil_rsp_o.rdata) && $stable(axil_rsp_o.rresp))
      else $error("Read answer dropped");
   a_ar_refused: assert property (axil_rsp_o.rvalid |-> !axil_rsp_o.arready)
      else $error("Read taken while answer pending");
   a_r_release: assert property (axil_rsp_o.rvalid && axil_req_i.rready |=>
      !axil_rsp_o.rvalid && axil_rsp_o.arready)
      else $error("Read side not freed");
   a_out_cause: assert property (
      !$stable({dout_o, brake_o}) |-> $past(axil_rsp_o.bvalid))
      else $error("Output moved without a write");
endmodule

bind dio_conditioning dio_conditioning_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_chk (
   .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .axil_req_i(axil_req_i),
   .axil_rsp_o(axil_rsp_o), .phys_in_i(phys_in_i), .aux_in_i(aux_in_i),
   .dout_o(dout_o), .brake_o(brake_o));

// >>> sim/tb.sv
// Self-checking bench for the digital input/output conditioning block.
// Assumes the sample period is shortened to SC clocks.
`timescale 1ns/1ps
module tb;
   import dio_pkg::*;
   localparam int unsigned SC = 8;
   logic sys_clk_i;
   logic reset_n_i;
   axil_req_s req;
   axil_rsp_s rsp;
   logic [15:0] lvl;
   logic [15:0] phys;
   logic [15:0] dout;
   aux_src_s aux_lvl;
   aux_src_s aux;
   logic brake;
   logic [31:0] s;
   logic [1:0] r;
   logic [31:0] cfg [2][5];
   logic [31:0] ocfg [3][4];
   logic [7:0] codes [32];
   int failures;
   int checked;
   int stall;

   dio_conditioning #(.SAMPLE_CYCLES(SC)) i_dio_conditioning (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .axil_req_i(req), .axil_rsp_o(rsp),
      .phys_in_i(phys), .aux_in_i(aux), .dout_o(dout), .brake_o(brake));
   dio_field_model i_dio_field_model (.sys_clk_i(sys_clk_i), .lvl_i(lvl),
      .aux_lvl_i(aux_lvl), .phys_o(phys), .aux_o(aux));

   function automatic logic [31:0] norm(input logic [31:0] ph, g, p, fe, fv);
      logic [15:0] v;
      v = ((ph[15:0] & ~fe[15:0]) | (fv[15:0] & fe[15:0])) ^ p[15:0];
      return {v, v & g[15:0]};
   endfunction

   function automatic logic src(input logic [7:0] c);
      logic b;
      b = 1'b0;
      if (c[6:0] >= 7'h01 && c[6:0] <= 7'h10) b = lvl[c[6:0] - 7'h01];
      if (c[6:0] >= 7'h41 && c[6:0] <= 7'h47) b = aux_lvl[c[6:0] - 7'h41];
      return b ^ c[7];
   endfunction

   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task results;
      $display("failures %0d checked %0d", failures, checked);
      if (failures == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Ready is held back by stall edges to exercise a waiting slave answer
   task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      req.awaddr <= a;
      req.wdata <= v;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      while (!done) begin
         @(posedge sys_clk_i);
         n++;
         if (rsp.bvalid && req.bready) begin
            done = 1'b1;
            rs = rsp.bresp;
         end else req.bready <= (n >= stall);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end
      req.bready <= 1'b0;
      @(posedge sys_clk_i);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      req.araddr <= a;
      req.arvalid <= 1'b1;
      while (!done) begin
         @(posedge sys_clk_i);
         n++;
         if (rsp.rvalid && req.rready) begin
            done = 1'b1;
            v = rsp.rdata;
            rs = rsp.rresp;
         end else req.rready <= (n >= stall);
         if (rsp.arready) req.arvalid <= 1'b0;
      end
      req.rready <= 1'b0;
      @(posedge sys_clk_i);
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] v;
      logic [1:0] rs;
      rd(a, v, rs);
      cmp(v, e);
   endtask

   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end

   initial begin
      repeat (20000) @(posedge sys_clk_i);
      failures++;
      results();
   end

   initial begin
      reset_n_i = 1'b0;
      req = '0;
      req.wstrb = 4'hf;
      lvl = 16'h0;
      aux_lvl = 7'h53;
      failures = 0;
      checked = 0;
      stall = 0;
      cfg = '{'{32'ha5c3, 32'hffff_0005, 32'h0102, 32'h0030, 32'h0010},
              '{32'h3c01, 32'h0007, 32'h8001, 32'h8000, 32'h0}};
      ocfg = '{'{32'h8001_0001, 32'h0, 32'h0, 32'h0},
               '{32'h8001_0001, 32'h1, 32'h0002_0000, 32'hffff_ffff},
               '{32'h0, 32'hffff_0000, 32'h1, 32'h1}};
      codes = '{8'h00, 8'h01, 8'h07, 8'h10, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47,
                8'h80, 8'h81, 8'h88, 8'h90, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7,
                8'h03, 8'h0c, 8'h8f, 8'h82, 8'h05, 8'h86, 8'h20, 8'ha0, 8'h0f, 8'h84};
      repeat (2) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      for (int i = 0; i < 13; i++) rchk(12'(4 * i), 32'h0);
      rd(12'h040, s, r);
      cmp({30'h0, r}, {30'h0, 2'b10});
      cmp(s, 32'h0);
      wr(12'h040, 32'h1, r);
      cmp({30'h0, r}, {30'h0, 2'b10});
      wr(12'h010, 32'hffff, r);
      cmp({30'h0, r}, {30'h0, 2'b00});
      rchk(12'h010, 32'h0);
      // Byte strobes: only byte 1 of the command lands
      req.wstrb <= 4'h2;
      wr(12'h01c, 32'h1234_5678, r);
      req.wstrb <= 4'hf;
      rchk(12'h01c, 32'h0000_5600);
      cmp({15'h0, brake, dout}, 32'h0);
      for (int c = 0; c < 2; c++) begin
         lvl <= cfg[c][0][15:0];
         for (int k = 1; k < 5; k++) wr(12'(4 * k - 4), cfg[c][k], r);
         repeat (SC + 4) @(posedge sys_clk_i);
         rchk(12'h010, cfg[c][0]);
         s = norm(cfg[c][0], cfg[c][1], cfg[c][2], cfg[c][3], cfg[c][4]);
         rchk(12'h018, s);
      end
      stall = 2;
      wr(12'h014, 32'h1, r);
      rchk(12'h018, s);
      wr(12'h004, 32'hffff, r);
      rchk(12'h018, s);
      s = 32'h0;
      for (int j = 0; j < 32; j++) begin
         wr(12'h100 + 12'(4 * j), {24'h0, codes[j]}, r);
         s[j] = src(codes[j]);
      end
      rchk(12'h104, {24'h0, codes[1]});
      rchk(12'h018, s);
      wr(12'h014, 32'h0, r);
      rchk(12'h018, norm(cfg[1][0], cfg[1][1], 32'hffff, cfg[1][3], cfg[1][4]));
      for (int o = 0; o < 3; o++) begin
         for (int k = 0; k < 4; k++) wr(k == 0 ? 12'h01c : 12'h020 + 12'(4 * k), ocfg[o][k], r);
         wr(12'h020, 32'hffff_ffff, r);
         wr(12'h030, 32'hffff_ffff, r);
         cmp({30'h0, r}, {30'h0, 2'b00});
         s = ((ocfg[o][0] & ~ocfg[o][2]) | (ocfg[o][3] & ocfg[o][2])) ^ ocfg[o][1];
         cmp({15'h0, brake, dout}, {15'h0, s[0], s[31:16]});
      end
      rchk(12'h020, 32'h0);
      results();
   end
endmodule
